// ### l1dc_ctrl.sv
`timescale 1ns/10ps
// Function
// - load-reserve loads word and reserves its aligned 32-byte granule
// - any non-faulting own store-conditional cancels the reservation, any address
// - matching snooped write or invalidate cancels the reservation
// - store-conditional stores only if reserved, else clears equal flag
// - reserve ops fault on write-through or enabled-and-locked cache
// - reserve miss: block fill if cacheable with cache enabled, else single beat
// - reserve ops use own bus encoding; tagged fetches use it too
// - reservation state drives active-low reservation pin always
// - enable bit is clear after power-up
// - no cache snooping while the cache is disabled
// - disabled cache ignores tags, all accesses single-beat on bus
// - cache-inhibit pin follows access attribute regardless of enable
// - disabled: block-zero alignment fault, touch no-op, others no effect
// - locked: no allocation, only snoop kills, flush/invalidate ops and flash change tags
// - locked load miss bursts to reload buffer, cache untouched
// - locked store hit normal, store miss handled write-through
// - locked snoop invalidation stays invalid until unlocked
// - flash invalidate clears whole cache, no broadcast, drops dirty
// - flash bit self-clears next clock when enabled; set/clear also ok
// - hard reset invalidates cache; soft reset keeps contents
module l1dc_ctrl
#(
  parameter int IDX_W = l1dc_pkg::IDX_W_DEF
)
(
  // clock and resets
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    soft_rst,
  // control bits written by software
  input  wire logic                    cfg_wr,
  input  wire logic                    dcache_enable_bit,
  input  wire logic                    dcache_lock_bit,
  input  wire logic                    dcache_flash_inval_bit,
  input  wire logic                    fetch_tag_type_bit,
  // core request
  input  wire l1dc_pkg::l1dc_req_s     req,
  // snooped bus traffic from other masters
  input  wire l1dc_pkg::l1dc_snoop_s   snoop,
  // control state seen by software
  output logic                         enable_ff,
  output logic                         lock_ff,
  output logic                         flash_ff,
  // core response
  output logic                         done_ff,
  output logic                         hit_ff,
  output logic                         store_done_ff,
  output logic                         cond_equal_flag,
  output logic                         cond_equal_upd_ff,
  output l1dc_pkg::l1dc_exc_e          exc_ff,
  output logic                         rld_fill_ff,
  // system bus request
  output l1dc_pkg::l1dc_bus_s          bus_ff,
  output logic                         cache_inhibit_out_n,
  output logic                         reservation_out_n,
  output logic                         snoop_hit_ff
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_s2_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  wire logic rst_n = rst_s2_ff;

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  logic nxt_enable;
  logic nxt_lock;
  logic nxt_flash;

  assign nxt_enable = cfg_wr ? dcache_enable_bit : enable_ff;
  assign nxt_lock   = cfg_wr ? dcache_lock_bit : lock_ff;
  // self-clear one clock after set when enabled; an explicit clear
  // from software works too
  assign nxt_flash  = cfg_wr ? dcache_flash_inval_bit
                    : (flash_ff && !enable_ff);

  // only a hard reset touches these; soft reset leaves them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_ff <= l1dc_pkg::RST_ENABLE;
      lock_ff   <= l1dc_pkg::RST_LOCK;
      flash_ff  <= 1'b0;
    end
    else
    begin
      enable_ff <= nxt_enable;
      lock_ff   <= nxt_lock;
      flash_ff  <= nxt_flash;
    end
  end

  // invalidation fires on the rising edge of the flash bit only
  logic flash_q_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flash_q_ff <= 1'b0;
    else
      flash_q_ff <= flash_ff;
  end

  wire logic flash_go = flash_ff && !flash_q_ff;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  wire logic is_load  = req.valid && req.op == l1dc_pkg::L1DC_OP_LOAD;
  wire logic is_store = req.valid && req.op == l1dc_pkg::L1DC_OP_STORE;
  wire logic is_lrsv  = req.valid && req.op == l1dc_pkg::L1DC_OP_LRSV;
  wire logic is_scnd  = req.valid && req.op == l1dc_pkg::L1DC_OP_SCND;
  wire logic is_zero  = req.valid && req.op == l1dc_pkg::L1DC_OP_ZERO;
  wire logic is_touch = req.valid && req.op == l1dc_pkg::L1DC_OP_TOUCH;
  wire logic is_fetch = req.valid && req.op == l1dc_pkg::L1DC_OP_FETCH;
  wire logic is_blkop = req.valid && (req.op == l1dc_pkg::L1DC_OP_FLUSH
                     || req.op == l1dc_pkg::L1DC_OP_CLEAN
                     || req.op == l1dc_pkg::L1DC_OP_INVAL);

  wire logic [IDX_W-1:0] req_idx =
    req.addr[l1dc_pkg::GRANULE_LSB +: IDX_W];
  wire logic [IDX_W-1:0] snp_idx =
    snoop.addr[l1dc_pkg::GRANULE_LSB +: IDX_W];

  // ----------------------------------------------------------------
  // tag store
  // ----------------------------------------------------------------
  logic tag_valid;
  wire logic on       = enable_ff;
  // disabled cache ignores tag status entirely
  wire logic hit      = on && tag_valid && !req.ci;
  wire logic locked   = on && lock_ff;
  wire logic rsv_fault = (is_lrsv || is_scnd)
                      && (req.wt || locked);

  // reservation exists?
  logic rsv_ff;
  logic [l1dc_pkg::ADDR_W-1:l1dc_pkg::GRANULE_LSB] rsv_gran_ff;

  wire logic scnd_ok = is_scnd && !rsv_fault && rsv_ff;

  // allocation only on cacheable miss in an enabled, unlocked cache
  wire logic alloc = on && !lock_ff && !req.ci && !tag_valid
                  && !rsv_fault && !flash_go
                  && (is_load || is_lrsv || is_touch
                      || (is_store && !req.wt) || scnd_ok || is_zero);

  // snoops only run when enabled; a snoop kill stays even when locked,
  // since no allocation happens until the lock drops
  wire logic snp_kill = on && snoop.valid
                     && (snoop.write || snoop.inval);

  // block invalidate hits its own entry only when enabled
  wire logic blk_kill = on && is_blkop
                     && req.op != l1dc_pkg::L1DC_OP_CLEAN;

  logic snp_look;
  // dirty lines are simply dropped by the flash, nothing goes out
  l1dc_tags #(.IDX_W(IDX_W)) u_tags
  (
    .clk       (clk),
    .rst_b     (rst_n),
    .look_idx  (req_idx),
    .look_hit  (tag_valid),
    .alloc     (alloc),
    .alloc_idx (req_idx),
    .kill      (snp_kill || blk_kill),
    .kill_idx  (snp_kill ? snp_idx : req_idx),
    .flash     (flash_go)
  );

  // snoop response view is the snoop kill itself; the tags are not probed
  assign snp_look = snp_kill;

  // ----------------------------------------------------------------
  // reservation
  // ----------------------------------------------------------------
  wire logic snp_rsv_match = snoop.valid && (snoop.write || snoop.inval)
    && snoop.addr[l1dc_pkg::ADDR_W-1:l1dc_pkg::GRANULE_LSB] == rsv_gran_ff;

  logic nxt_rsv;
  logic [l1dc_pkg::ADDR_W-1:l1dc_pkg::GRANULE_LSB] nxt_rsv_gran;

  // a new reservation is applied last and so would win over own
  // store-conditional; single request port makes them exclusive
  always_comb
  begin
    nxt_rsv      = rsv_ff;
    nxt_rsv_gran = rsv_gran_ff;
    if (snp_rsv_match)
      nxt_rsv = 1'b0;
    if (is_scnd && !rsv_fault)
      nxt_rsv = 1'b0;
    if (is_lrsv && !rsv_fault)
    begin
      nxt_rsv      = 1'b1;
      nxt_rsv_gran = req.addr[l1dc_pkg::ADDR_W-1:l1dc_pkg::GRANULE_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsv_ff      <= l1dc_pkg::RST_RSV;
      rsv_gran_ff <= '0;
    end
    else
    begin
      rsv_ff      <= nxt_rsv;
      rsv_gran_ff <= nxt_rsv_gran;
    end
  end

  // ----------------------------------------------------------------
  // bus request build
  // ----------------------------------------------------------------
  wire logic needs_bus = req.valid && !rsv_fault && !hit
    && !(is_zero && !on) && !is_blkop
    && !(is_touch && (!on || lock_ff || req.ci))
    && !(is_scnd && !rsv_ff)
    && !(is_store && hit);

  // burst only for a cacheable fill with the cache on; locked load
  // misses still burst into the reload buffer
  wire logic burst = on && !req.ci
    && (is_load || is_lrsv || is_touch || (is_store && !req.wt && !lock_ff));

  l1dc_pkg::l1dc_tt_e nxt_tt;

  assign nxt_tt =
    (is_lrsv && burst)  ? l1dc_pkg::L1DC_TT_LRSVB :
    (is_lrsv)           ? l1dc_pkg::L1DC_TT_LRSV :
    (is_scnd)           ? l1dc_pkg::L1DC_TT_SCND :
    (is_fetch && fetch_tag_type_bit) ? l1dc_pkg::L1DC_TT_LRSV :
    (is_store)          ? l1dc_pkg::L1DC_TT_WRITE :
    (burst)             ? l1dc_pkg::L1DC_TT_BURST :
                          l1dc_pkg::L1DC_TT_READ;

  l1dc_pkg::l1dc_bus_s nxt_bus;

  always_comb
  begin
    nxt_bus.valid       = needs_bus;
    nxt_bus.tt          = needs_bus ? nxt_tt : l1dc_pkg::L1DC_TT_NONE;
    nxt_bus.single_beat = !burst;
    nxt_bus.addr        = req.addr;
  end

  // ----------------------------------------------------------------
  // response build
  // ----------------------------------------------------------------
  l1dc_pkg::l1dc_exc_e nxt_exc;

  assign nxt_exc = rsv_fault ? l1dc_pkg::L1DC_EXC_DSI :
                   (is_zero && !on) ? l1dc_pkg::L1DC_EXC_ALIGN
                   : l1dc_pkg::L1DC_EXC_NONE;

  // store done: ordinary store or successful store-conditional
  wire logic nxt_store_done = (is_store || scnd_ok) && !rsv_fault;
  // locked load miss fills the reload buffer only; a locked store miss goes write-through
  wire logic nxt_rld = (is_load || is_lrsv) && locked
                    && !tag_valid && !req.ci && !rsv_fault;

  logic eq_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_ff           <= 1'b0;
      hit_ff            <= 1'b0;
      store_done_ff     <= 1'b0;
      eq_ff             <= 1'b0;
      cond_equal_upd_ff <= 1'b0;
      exc_ff            <= l1dc_pkg::L1DC_EXC_NONE;
      rld_fill_ff       <= 1'b0;
      bus_ff            <= '0;
      snoop_hit_ff      <= 1'b0;
    end
    else
    begin
      done_ff           <= req.valid;
      hit_ff            <= hit && req.valid;
      store_done_ff     <= nxt_store_done;
      eq_ff             <= scnd_ok;
      cond_equal_upd_ff <= is_scnd && !rsv_fault;
      exc_ff            <= nxt_exc;
      rld_fill_ff       <= nxt_rld;
      bus_ff            <= nxt_bus;
      snoop_hit_ff      <= snp_look;
    end
  end

  assign cond_equal_flag = eq_ff;

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // pins reflect registered state so they stay glitch free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cache_inhibit_out_n <= 1'b1;
      reservation_out_n   <= 1'b1;
    end
    else
    begin
      cache_inhibit_out_n <= !(needs_bus && req.ci);
      reservation_out_n   <= !nxt_rsv;
    end
  end

  // soft reset is accepted but deliberately changes no cache state
  wire logic unused_soft = soft_rst;

endmodule

// ### l1dc_pkg.sv
package l1dc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W       = 32;
  localparam int GRANULE_LSB  = 5;
  localparam int SETS_DEF     = 128;
  localparam int IDX_W_DEF    = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_LOCK   = 1'b0;
  localparam logic RST_RSV    = 1'b0;

  // ----------------------------------------------------------------
  // access kinds and bus transfer types
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    L1DC_OP_LOAD  = 4'h0,
    L1DC_OP_STORE = 4'h1,
    L1DC_OP_LRSV  = 4'h2,
    L1DC_OP_SCND  = 4'h3,
    L1DC_OP_ZERO  = 4'h4,
    L1DC_OP_TOUCH = 4'h5,
    L1DC_OP_FLUSH = 4'h6,
    L1DC_OP_CLEAN = 4'h7,
    L1DC_OP_INVAL = 4'h8,
    L1DC_OP_FETCH = 4'h9
  } l1dc_op_e;

  typedef enum logic [3:0]
  {
    L1DC_TT_NONE  = 4'h0,
    L1DC_TT_READ  = 4'h1,
    L1DC_TT_BURST = 4'h2,
    L1DC_TT_WRITE = 4'h3,
    L1DC_TT_LRSV  = 4'h4,
    L1DC_TT_LRSVB = 4'h5,
    L1DC_TT_SCND  = 4'h6
  } l1dc_tt_e;

  typedef enum logic [2:0]
  {
    L1DC_EXC_NONE  = 3'h0,
    L1DC_EXC_DSI   = 3'h1,
    L1DC_EXC_ALIGN = 3'h2
  } l1dc_exc_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic                valid;
    l1dc_op_e            op;
    logic [ADDR_W-1:0]   addr;
    logic                wt;
    logic                ci;
  } l1dc_req_s;

  typedef struct packed
  {
    logic                valid;
    l1dc_tt_e            tt;
    logic                single_beat;
    logic [ADDR_W-1:0]   addr;
  } l1dc_bus_s;

  typedef struct packed
  {
    logic                valid;
    logic                write;
    logic                inval;
    logic [ADDR_W-1:0]   addr;
  } l1dc_snoop_s;

endpackage

// ### l1dc_tags.sv
`timescale 1ns/10ps
// per-set valid bits with a single-cycle flash clear
module l1dc_tags
#(
  parameter int IDX_W = 7
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // lookup
  input  wire logic [IDX_W-1:0] look_idx,
  output logic                  look_hit,
  // updates
  input  wire logic             alloc,
  input  wire logic [IDX_W-1:0] alloc_idx,
  input  wire logic             kill,
  input  wire logic [IDX_W-1:0] kill_idx,
  input  wire logic             flash
);

  logic [(1<<IDX_W)-1:0] valid_ff;
  logic [(1<<IDX_W)-1:0] nxt_valid;

  assign look_hit = valid_ff[look_idx];

  // kill beats alloc on the same set; flash beats both
  always_comb
  begin
    nxt_valid = valid_ff;
    if (alloc)
      nxt_valid[alloc_idx] = 1'b1;
    if (kill)
      nxt_valid[kill_idx] = 1'b0;
    if (flash)
      nxt_valid = '0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      valid_ff <= '0;
    else
      valid_ff <= nxt_valid;
  end

endmodule

// ### l1dc_ctrl_chk.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker for the data cache control block
// ----------------------------------------------------------------
module l1dc_chk
#(
  parameter int IDX_W = 7
)
(
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // stimulus
  input wire logic                  cfg_wr,
  input wire l1dc_pkg::l1dc_req_s   req,
  input wire l1dc_pkg::l1dc_snoop_s snoop,
  // responses
  input wire logic                  enable_ff,
  input wire logic                  lock_ff,
  input wire logic                  flash_ff,
  input wire l1dc_pkg::l1dc_exc_e   exc_ff,
  input wire l1dc_pkg::l1dc_bus_s   bus_ff,
  input wire logic                  cache_inhibit_out_n,
  input wire logic                  reservation_out_n,
  input wire logic                  snoop_hit_ff
);
  logic is_lr;
  logic is_sc;
  logic is_ld;
  logic refuse;
  assign is_lr  = req.valid && req.op == l1dc_pkg::L1DC_OP_LRSV;
  assign is_sc  = req.valid && req.op == l1dc_pkg::L1DC_OP_SCND;
  assign is_ld  = req.valid && req.op == l1dc_pkg::L1DC_OP_LOAD;
  assign refuse = req.wt || (enable_ff && lock_ff);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_lr_ok;
    is_lr && !refuse;
  endsequence
  sequence s_sc_ok;
    is_sc && !refuse;
  endsequence

  property p_rsv_set;
    s_lr_ok |=> !reservation_out_n;
  endproperty
  a_rsv_set: assert property (p_rsv_set)
    else $error("reservation pin not set");

  property p_sc_cancel;
    s_sc_ok |=> reservation_out_n;
  endproperty
  a_sc_cancel: assert property (p_sc_cancel)
    else $error("reservation kept after store-conditional");

  property p_refuse;
    (is_lr || is_sc) && refuse
      |=> exc_ff == l1dc_pkg::L1DC_EXC_DSI && !bus_ff.valid;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("reserve op not refused");

  property p_lr_single;
    s_lr_ok ##0 req.ci |=> bus_ff.valid && bus_ff.single_beat
      && bus_ff.tt == l1dc_pkg::L1DC_TT_LRSV;
  endproperty
  a_lr_single: assert property (p_lr_single)
    else $error("inhibited reserve load not single beat");

  property p_ci_pin;
    is_ld |=> cache_inhibit_out_n == !$past(req.ci);
  endproperty
  a_ci_pin: assert property (p_ci_pin)
    else $error("inhibit pin mismatch");

  property p_dis_single;
    is_ld && !enable_ff |=> bus_ff.valid && bus_ff.single_beat;
  endproperty
  a_dis_single: assert property (p_dis_single)
    else $error("disabled load not single beat");

  property p_no_snoop;
    snoop.valid && !enable_ff |=> !snoop_hit_ff;
  endproperty
  a_no_snoop: assert property (p_no_snoop)
    else $error("snoop hit while disabled");

  property p_flash_clr;
    $rose(flash_ff) && enable_ff && !cfg_wr |=> !flash_ff;
  endproperty
  a_flash_clr: assert property (p_flash_clr)
    else $error("flash bit did not clear");

  property p_align;
    req.valid && req.op == l1dc_pkg::L1DC_OP_ZERO && !enable_ff
      |=> exc_ff == l1dc_pkg::L1DC_EXC_ALIGN;
  endproperty
  a_align: assert property (p_align)
    else $error("block zero not faulted");
endmodule

bind l1dc_ctrl l1dc_chk #(.IDX_W(IDX_W)) u_l1dc_chk
(
  .clk                 (clk),
  .rst_b               (rst_b),
  .cfg_wr              (cfg_wr),
  .req                 (req),
  .snoop               (snoop),
  .enable_ff           (enable_ff),
  .lock_ff             (lock_ff),
  .flash_ff            (flash_ff),
  .exc_ff              (exc_ff),
  .bus_ff              (bus_ff),
  .cache_inhibit_out_n (cache_inhibit_out_n),
  .reservation_out_n   (reservation_out_n),
  .snoop_hit_ff        (snoop_hit_ff)
);

// ### l1dc_peer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// other bus master: issues one snoop, promptly or after a lag
// ----------------------------------------------------------------
module l1dc_peer
(
  // clock
  input wire logic              clk,
  // command from the bench
  input wire logic              go,
  input wire logic              write,
  input wire logic              inval,
  input wire logic [31:0]       addr,
  input wire logic [3:0]        lag,
  // snooped traffic
  output l1dc_pkg::l1dc_snoop_s snoop
);
  int                    left = -1;
  l1dc_pkg::l1dc_snoop_s snp_q = '0;

  // one driver for the port keeps the snooped bus single-sourced
  assign snoop = snp_q;

  // idle address wanders so a stale value never looks like a match
  always @(posedge clk)
  begin
    if (go)
      left = int'(lag);
    if (left == 0)
      snp_q <= '{1'b1, write, inval, addr};
    else
    begin
      snp_q.valid <= 1'b0;
      snp_q.addr  <= ~snp_q.addr;
    end
    if (left >= 0)
      left = left - 1;
  end
endmodule

// ### l1dc_ctrl_test.sv
`timescale 1ns/10ps
module l1dc_ctrl_test;
  logic                  clk = 1'b0;
  logic                  rst_b;
  logic                  soft_rst;
  logic                  cfg_wr;
  logic                  dcache_enable_bit;
  logic                  dcache_lock_bit;
  logic                  dcache_flash_inval_bit;
  logic                  fetch_tag_type_bit;
  l1dc_pkg::l1dc_req_s   req;
  l1dc_pkg::l1dc_snoop_s snoop;
  logic                  enable_ff;
  logic                  lock_ff;
  logic                  flash_ff;
  logic                  done_ff;
  logic                  hit_ff;
  logic                  store_done_ff;
  logic                  cond_equal_flag;
  logic                  cond_equal_upd_ff;
  l1dc_pkg::l1dc_exc_e   exc_ff;
  logic                  rld_fill_ff;
  l1dc_pkg::l1dc_bus_s   bus_ff;
  logic                  cache_inhibit_out_n;
  logic                  reservation_out_n;
  logic                  snoop_hit_ff;
  logic                  go;
  logic                  s_w;
  logic                  s_i;
  logic [31:0]           s_a;
  logic [3:0]            s_lag;
  int                    fails = 0;
  int                    checks = 0;

  initial forever #5 clk = ~clk;

  l1dc_ctrl #(.IDX_W(7)) u_l1dc_ctrl
  (
    .clk(clk), .rst_b(rst_b), .soft_rst(soft_rst), .cfg_wr(cfg_wr),
    .dcache_enable_bit(dcache_enable_bit),
    .dcache_lock_bit(dcache_lock_bit),
    .dcache_flash_inval_bit(dcache_flash_inval_bit),
    .fetch_tag_type_bit(fetch_tag_type_bit), .req(req), .snoop(snoop),
    .enable_ff(enable_ff), .lock_ff(lock_ff), .flash_ff(flash_ff),
    .done_ff(done_ff), .hit_ff(hit_ff), .store_done_ff(store_done_ff),
    .cond_equal_flag(cond_equal_flag),
    .cond_equal_upd_ff(cond_equal_upd_ff), .exc_ff(exc_ff),
    .rld_fill_ff(rld_fill_ff), .bus_ff(bus_ff),
    .cache_inhibit_out_n(cache_inhibit_out_n),
    .reservation_out_n(reservation_out_n), .snoop_hit_ff(snoop_hit_ff)
  );

  l1dc_peer u_l1dc_peer
  (
    .clk(clk), .go(go), .write(s_w), .inval(s_i), .addr(s_a),
    .lag(s_lag), .snoop(snoop)
  );

  task chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected bit at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task chk_code(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected code at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // core is idle around every write, as software syncs first
  task cfg(input logic en, input logic lk, input logic fl, input logic ft);
    @(posedge clk);
    cfg_wr                 <= 1'b1;
    dcache_enable_bit      <= en;
    dcache_lock_bit        <= lk;
    dcache_flash_inval_bit <= fl;
    fetch_tag_type_bit     <= ft;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
  endtask

  task acc(input l1dc_pkg::l1dc_op_e op, input logic [31:0] a,
           input logic wt, input logic ci);
    @(posedge clk);
    req <= '{1'b1, op, a, wt, ci};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
  endtask

  task snp(input logic w, input logic iv, input logic [31:0] a,
           input logic [3:0] lg);
    @(posedge clk);
    go    <= 1'b1;
    s_w   <= w;
    s_i   <= iv;
    s_a   <= a;
    s_lag <= lg;
    @(posedge clk);
    go <= 1'b0;
    // stop on the edge where the snoop is taken so its pulse is seen
    repeat (int'(lg) + 1) @(posedge clk);
    #1;
  endtask

  initial
  begin
    {rst_b, soft_rst, cfg_wr, go, s_w, s_i, s_a, s_lag} = '0;
    {dcache_enable_bit, dcache_lock_bit} = 2'h0;
    {dcache_flash_inval_bit, fetch_tag_type_bit} = 2'h0;
    req = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(enable_ff, 1'b0);
    chk_bit(reservation_out_n, 1'b1);
    $display("test reset done");
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h40, 1'b0, 1'b0);
    chk_bit(bus_ff.single_beat, 1'b1);
    chk_bit(done_ff, 1'b1);
    chk_bit(cache_inhibit_out_n, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h40, 1'b0, 1'b1);
    chk_bit(cache_inhibit_out_n, 1'b0);
    acc(l1dc_pkg::L1DC_OP_ZERO, 32'h40, 1'b0, 1'b0);
    chk_code({1'b0, exc_ff}, {1'b0, l1dc_pkg::L1DC_EXC_ALIGN});
    for (int i = 5; i < 9; i++)
    begin
      acc(l1dc_pkg::l1dc_op_e'(i), 32'h40, 1'b0, 1'b0);
      chk_code({1'b0, exc_ff}, 4'h0);
    end
    snp(1'b1, 1'b0, 32'h40, 4'h0);
    chk_bit(snoop_hit_ff, 1'b0);
    $display("test disabled done");
    acc(l1dc_pkg::L1DC_OP_LRSV, 32'h100, 1'b0, 1'b1);
    chk_code(bus_ff.tt, l1dc_pkg::L1DC_TT_LRSV);
    chk_bit(bus_ff.single_beat, 1'b1);
    chk_bit(reservation_out_n, 1'b0);
    snp(1'b1, 1'b0, 32'h11c, 4'h3);
    chk_bit(reservation_out_n, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LRSV, 32'h11c, 1'b0, 1'b1);
    snp(1'b1, 1'b0, 32'h120, 4'h0);
    chk_bit(reservation_out_n, 1'b0);
    snp(1'b0, 1'b1, 32'h104, 4'h0);
    chk_bit(reservation_out_n, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LRSV, 32'h100, 1'b0, 1'b1);
    acc(l1dc_pkg::L1DC_OP_SCND, 32'h4000, 1'b0, 1'b1);
    chk_code(bus_ff.tt, l1dc_pkg::L1DC_TT_SCND);
    chk_bit(store_done_ff, 1'b1);
    chk_bit(cond_equal_flag, 1'b1);
    chk_bit(reservation_out_n, 1'b1);
    acc(l1dc_pkg::L1DC_OP_SCND, 32'h100, 1'b0, 1'b1);
    chk_bit(store_done_ff, 1'b0);
    chk_bit(cond_equal_upd_ff, 1'b1);
    chk_bit(cond_equal_flag, 1'b0);
    $display("test reservation done");
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    acc(l1dc_pkg::L1DC_OP_LRSV, 32'h200, 1'b0, 1'b0);
    chk_code(bus_ff.tt, l1dc_pkg::L1DC_TT_LRSVB);
    chk_bit(bus_ff.single_beat, 1'b0);
    acc(l1dc_pkg::L1DC_OP_LRSV, 32'h200, 1'b1, 1'b0);
    chk_code({1'b0, exc_ff}, {1'b0, l1dc_pkg::L1DC_EXC_DSI});
    cfg(1'b1, 1'b0, 1'b0, 1'b1);
    acc(l1dc_pkg::L1DC_OP_FETCH, 32'h300, 1'b0, 1'b1);
    chk_bit(bus_ff.tt == l1dc_pkg::L1DC_TT_LRSV ||
            bus_ff.tt == l1dc_pkg::L1DC_TT_LRSVB, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h500, 1'b0, 1'b0);
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h500, 1'b0, 1'b0);
    chk_bit(hit_ff, 1'b1);
    cfg(1'b1, 1'b0, 1'b1, 1'b0);
    chk_bit(flash_ff, 1'b1);
    @(posedge clk);
    #1;
    chk_bit(flash_ff, 1'b0);
    chk_bit(bus_ff.valid, 1'b0);
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h500, 1'b0, 1'b0);
    chk_bit(hit_ff, 1'b0);
    $display("test enabled done");
    // locked: snoop invalidation sticks, load misses fill the reload buffer
    cfg(1'b1, 1'b1, 1'b0, 1'b0);
    chk_bit(lock_ff, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h500, 1'b0, 1'b0);
    chk_bit(hit_ff, 1'b1);
    snp(1'b0, 1'b1, 32'h500, 4'h0);
    chk_bit(snoop_hit_ff, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h500, 1'b0, 1'b0);
    chk_bit(hit_ff, 1'b0);
    chk_bit(rld_fill_ff, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h600, 1'b0, 1'b0);
    chk_bit(rld_fill_ff, 1'b1);
    chk_bit(bus_ff.single_beat, 1'b0);
    acc(l1dc_pkg::L1DC_OP_LOAD, 32'h600, 1'b0, 1'b0);
    chk_bit(hit_ff, 1'b0);
    acc(l1dc_pkg::L1DC_OP_STORE, 32'h700, 1'b0, 1'b0);
    chk_code(bus_ff.tt, l1dc_pkg::L1DC_TT_WRITE);
    chk_bit(bus_ff.single_beat, 1'b1);
    acc(l1dc_pkg::L1DC_OP_LRSV, 32'h800, 1'b0, 1'b1);
    chk_code({1'b0, exc_ff}, {1'b0, l1dc_pkg::L1DC_EXC_DSI});
    $display("test locked done");
    print_verdict;
  end
endmodule
